//--- tsc_pkg.sv
// Purpose: constants and carrier types for the trigger timestamp counter
// Assumes: 250 MHz core clock, register port with one-cycle read latency
// Notes: register offsets are word indices, byte address is four times the index
package tsc_pkg;
  // ==========================================================================
  // Register indices and byte address width
  localparam logic [19:0] TSC_IDX_RATE = 20'h04E20;
  localparam logic [19:0] TSC_IDX_CMD = 20'h0B798;
  localparam logic [19:0] TSC_IDX_AVAIL = 20'h0B799;
  localparam logic [19:0] TSC_IDX_TIME = 20'h0B7B6;
  localparam logic [19:0] TSC_IDX_DATE = 20'h0B7B7;
  localparam logic [19:0] TSC_IDX_TMO = 20'h0B7C5;
  localparam logic [19:0] TSC_IDX_MULT = 20'h30DBB;
  localparam logic [19:0] TSC_IDX_STAT = 20'h0B7C6;
  localparam logic [19:0] TSC_IDX_PCTIME = 20'h0B7C7;
  localparam logic [19:0] TSC_IDX_PCDATE = 20'h0B7C8;
  localparam int TSC_AW = 22;
  // ==========================================================================
  // Command codes
  localparam logic [31:0] TSC_CMD_OFF = 32'h0000_0000;
  localparam logic [31:0] TSC_CMD_CLEAR = 32'h0000_0001;
  localparam logic [31:0] TSC_CMD_FREE = 32'h0000_0002;
  localparam logic [31:0] TSC_CMD_ARM = 32'h0000_0004;
  localparam logic [31:0] TSC_CNT_FULL = 32'h0000_0100;
  localparam logic [31:0] TSC_CNT_RISE = 32'h0000_0200;
  localparam logic [31:0] TSC_CNT_FALL = 32'h0000_0400;
  localparam logic [31:0] TSC_AUX_ON = 32'h0000_1000;
  localparam logic [31:0] TSC_CMD_RST = 32'h0000_0000;
  localparam logic [31:0] TSC_TMO_RST = 32'h0000_03E8;
  localparam logic [31:0] TSC_MULT_RST = 32'h0000_0001;
  localparam logic [31:0] TSC_RATE_RST = 32'h0773_5940;
  // Status bits
  localparam int TSC_ST_BUSY = 0;
  localparam int TSC_ST_TMO = 1;
  localparam int TSC_ST_FOUND = 2;
  // ==========================================================================
  // Timing
  localparam int TSC_CLK_MHZ = 250;
  localparam int TSC_MS_US = 1000;
  localparam int TSC_CYC_PER_MS = TSC_CLK_MHZ * TSC_MS_US;
  localparam int TSC_SAMP_DIV = 2;
  // ==========================================================================
  typedef enum logic [1:0] {TSC_SRC_FULL, TSC_SRC_RISE, TSC_SRC_FALL} tsc_src_e;
  typedef enum logic [1:0] {TSC_M_OFF, TSC_M_FREE, TSC_M_ARM} tsc_mode_e;
  typedef struct packed {
    logic [19:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tsc_bus_s;
  typedef struct packed {
    logic valid;
    logic [63:0] stamp;
  } tsc_push_s;
endpackage

//--- tsc_sync.sv
// Purpose: two flip-flop synchroniser for one asynchronous level
// Assumes: single destination clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module tsc_sync (
  input wire logic core_clk, // Destination clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic din, // Asynchronous level
  output logic dout // Synchronised level
);
  logic meta_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

//--- tsc_top.sv
// Purpose: 64-bit trigger timestamp counter with reference clock split mode
// Assumes: sample enable marks the non-interlaced sampling clock
// Notes: register reads answer one cycle after the read strobe
// Operation
// - Each stamp is 64 bits at sampling rate
// - Trigger pushes the counter value out
// - Gate open and close each push stamp
// - Mode 0 off, 2h free, 4h arm-clear
// - Clear command zeroes counter in free mode
// - Free mode ignores acquisition start and stop
// - Arm-clear mode zeroes counter at every start
// - Source 100h full, 200h rise, 400h fall
// - Split mode: high counts edges, low samples
// - Reference edge clears low, increments high
// - Clear command zeroes both halves in split
// - Split clear waits edge, flags timeout error
// - Time register hours, minutes, seconds at edge
// - Date register year, month, day fields
// - Read-only bitmap lists supported modes, sources
// - Aux capture puts inputs in upper byte
// - Aux capture off zero-fills upper byte
// - Count at non-interlaced rate, max 125 MS/s
// - Split modes inert without reference input option
// - Multiplier register reads 1 without oversampling
`timescale 1ns/1ps
module tsc_top import tsc_pkg::*; #(
  parameter logic REF_PRESENT = 1'b1, // Reference input option fitted
  parameter logic [31:0] SAMPLE_RATE = TSC_RATE_RST, // Reported sampling rate
  parameter logic [31:0] MULTIPLIER = TSC_MULT_RST, // Oversampling factor
  parameter int CYC_PER_MS = TSC_CYC_PER_MS // Cycles per millisecond
) (
  input wire logic core_clk, // 250 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire tsc_bus_s bus, // Register request
  output logic [31:0] rdata, // Read data, one cycle after read
  input wire logic samp_en, // Sampling clock enable, same domain
  input wire logic acq_start, // Acquisition start pulse
  input wire logic trig, // Trigger event pulse
  input wire logic gate, // Gate level, same domain
  input wire logic ref_clk_in, // External reference pulse, asynchronous
  input wire logic [7:0] aux_in, // Auxiliary inputs, asynchronous
  input wire logic [31:0] pc_time, // Host time of day
  input wire logic [31:0] pc_date, // Host calendar date
  output tsc_push_s push // Stamp towards the stamp FIFO
);
  logic [31:0] cmd_r;
  logic [31:0] tmo_r;
  logic [31:0] time_r;
  logic [31:0] date_r;
  logic [31:0] hi_r;
  logic [31:0] lo_r;
  logic [31:0] ms_cnt_r;
  logic [31:0] cyc_cnt_r;
  logic busy_r;
  logic tmo_err_r;
  logic found_r;
  logic ref_q_r;
  logic gate_q_r;
  logic ref_s;
  logic [7:0] aux_s;
  logic ref_edge;
  logic clr_req;
  logic wr_cmd;
  logic stamp_ev;
  tsc_mode_e mode;
  tsc_src_e src;
  logic [31:0] avail;
  logic [31:0] stat;

  // ==========================================================================
  // Input synchronisers
  tsc_sync u_ref (.core_clk(core_clk), .rst(rst), .ce(ce), .din(ref_clk_in), .dout(ref_s));
  for (genvar i = 0; i < 8; i++) begin : g_aux
    tsc_sync u_aux (.core_clk(core_clk), .rst(rst), .ce(ce), .din(aux_in[i]), .dout(aux_s[i]));
  end

  // ==========================================================================
  // Command decode
  always_comb begin
    if ((cmd_r & TSC_CMD_FREE) != 32'h0) begin
      mode = TSC_M_FREE;
    end else if ((cmd_r & TSC_CMD_ARM) != 32'h0) begin
      mode = TSC_M_ARM;
    end else begin
      mode = TSC_M_OFF;
    end
    if (REF_PRESENT && (cmd_r & TSC_CNT_RISE) != 32'h0) begin
      src = TSC_SRC_RISE;
    end else if (REF_PRESENT && (cmd_r & TSC_CNT_FALL) != 32'h0) begin
      src = TSC_SRC_FALL;
    end else begin
      src = TSC_SRC_FULL;
    end
  end

  assign wr_cmd = bus.wr && bus.addr == TSC_IDX_CMD;
  assign clr_req = wr_cmd && (bus.wdata & TSC_CMD_CLEAR) != 32'h0;

  always_comb begin
    case (src)
      TSC_SRC_RISE: ref_edge = ref_s && !ref_q_r;
      TSC_SRC_FALL: ref_edge = !ref_s && ref_q_r;
      default: ref_edge = 1'b0;
    endcase
  end

  // ==========================================================================
  // Registers written by software
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_r <= TSC_CMD_RST;
      tmo_r <= TSC_TMO_RST;
    end else if (ce && bus.wr) begin
      if (bus.addr == TSC_IDX_CMD && (bus.wdata & ~TSC_CMD_CLEAR) != 32'h0) begin
        cmd_r <= bus.wdata & ~TSC_CMD_CLEAR; // Clear is a one-shot, the mode stays
      end else if (bus.addr == TSC_IDX_CMD && bus.wdata == TSC_CMD_OFF) begin
        cmd_r <= TSC_CMD_OFF;
      end
      if (bus.addr == TSC_IDX_TMO) begin
        tmo_r <= bus.wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_q_r <= 1'b0;
      gate_q_r <= 1'b0;
    end else if (ce) begin
      ref_q_r <= ref_s;
      gate_q_r <= gate;
    end
  end

  // ==========================================================================
  // Clear sequence with edge wait in split mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      tmo_err_r <= 1'b0;
      found_r <= 1'b0;
      ms_cnt_r <= 32'h0;
      cyc_cnt_r <= 32'h0;
    end else if (ce) begin
      if (clr_req && src != TSC_SRC_FULL) begin
        busy_r <= 1'b1;
        tmo_err_r <= 1'b0;
        found_r <= 1'b0;
        ms_cnt_r <= 32'h0;
        cyc_cnt_r <= 32'h0;
      end else if (busy_r) begin
        if (ref_edge) begin
          busy_r <= 1'b0;
          found_r <= 1'b1;
        end else if (ms_cnt_r >= tmo_r) begin
          busy_r <= 1'b0;
          tmo_err_r <= 1'b1;
        end else if (src == TSC_SRC_FULL) begin
          busy_r <= 1'b0; // Leaving split mode drops a pending wait
        end else if (cyc_cnt_r == 32'(CYC_PER_MS - 1)) begin
          cyc_cnt_r <= 32'h0;
          ms_cnt_r <= ms_cnt_r + 32'h1;
        end else begin
          cyc_cnt_r <= cyc_cnt_r + 32'h1;
        end
      end
    end
  end

  // Time and date caught when the edge is found; capture beats a software write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      time_r <= 32'h0;
      date_r <= 32'h0;
    end else if (ce) begin
      if (busy_r && ref_edge) begin
        time_r <= {8'h00, pc_time[23:16], pc_time[15:8], pc_time[7:0]};
        date_r <= {pc_date[31:16], pc_date[15:8], pc_date[7:0]};
      end else if (bus.wr) begin
        if (bus.addr == TSC_IDX_TIME) begin
          time_r <= bus.wdata;
        end
        if (bus.addr == TSC_IDX_DATE) begin
          date_r <= bus.wdata;
        end
      end
    end
  end

  // ==========================================================================
  // Counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hi_r <= 32'h0;
      lo_r <= 32'h0;
    end else if (ce) begin
      if (clr_req && src == TSC_SRC_FULL) begin
        hi_r <= 32'h0;
        lo_r <= 32'h0;
      end else if (busy_r && src != TSC_SRC_FULL) begin
        hi_r <= 32'h0;
        lo_r <= 32'h0;
      end else if (mode == TSC_M_ARM && acq_start) begin
        hi_r <= 32'h0;
        lo_r <= 32'h0;
      end else if (mode != TSC_M_OFF) begin
        if (src != TSC_SRC_FULL && ref_edge) begin
          hi_r <= hi_r + 32'h1;
          lo_r <= 32'h0;
        end else if (samp_en) begin
          if (src == TSC_SRC_FULL) begin
            {hi_r, lo_r} <= {hi_r, lo_r} + 64'h1;
          end else begin
            lo_r <= lo_r + 32'h1;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Stamp output
  assign stamp_ev = trig || (gate && !gate_q_r) || (!gate && gate_q_r);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      push <= '0;
    end else if (ce) begin
      push.valid <= stamp_ev && mode != TSC_M_OFF;
      if ((cmd_r & TSC_AUX_ON) != 32'h0) begin
        push.stamp <= {aux_s, hi_r[23:0], lo_r};
      end else begin
        push.stamp <= {8'h00, hi_r[23:0], lo_r};
      end
    end
  end

  // ==========================================================================
  // Read port
  assign avail = TSC_CMD_FREE | TSC_CMD_ARM | TSC_CNT_FULL | TSC_AUX_ON
    | (REF_PRESENT ? (TSC_CNT_RISE | TSC_CNT_FALL) : 32'h0);
  assign stat = {29'h0, found_r, tmo_err_r, busy_r};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (ce) begin
      if (bus.rd) begin
        case (bus.addr)
          TSC_IDX_RATE: rdata <= SAMPLE_RATE;
          TSC_IDX_CMD: rdata <= cmd_r;
          TSC_IDX_AVAIL: rdata <= avail;
          TSC_IDX_TIME: rdata <= time_r;
          TSC_IDX_DATE: rdata <= date_r;
          TSC_IDX_TMO: rdata <= tmo_r;
          TSC_IDX_MULT: rdata <= MULTIPLIER;
          TSC_IDX_STAT: rdata <= stat;
          TSC_IDX_PCTIME: rdata <= hi_r;
          TSC_IDX_PCDATE: rdata <= lo_r;
          default: rdata <= 32'h0;
        endcase
      end else begin
        rdata <= 32'h0;
      end
    end
  end

  // ==========================================================================
  // Checks
  AST_TRIG_PUSH: assert property (@(posedge core_clk) disable iff (rst)
    ce && trig && mode != TSC_M_OFF |=> push.valid)
    else $error("trigger did not push a stamp");
  AST_OFF_SILENT: assert property (@(posedge core_clk) disable iff (rst)
    ce && cmd_r == TSC_CMD_OFF |=> !push.valid)
    else $error("stamp pushed while off");
  AST_CLEAR_FULL: assert property (@(posedge core_clk) disable iff (rst)
    ce && clr_req && src == TSC_SRC_FULL |=> hi_r == 32'h0 && lo_r == 32'h0)
    else $error("clear did not zero counter");
  AST_ARM_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    ce && !clr_req && !busy_r && mode == TSC_M_ARM && acq_start |=> lo_r == 32'h0 && hi_r == 32'h0)
    else $error("start did not clear counter");
  AST_REF_EDGE: assert property (@(posedge core_clk) disable iff (rst)
    ce && !busy_r && !clr_req && mode != TSC_M_OFF && !(mode == TSC_M_ARM && acq_start) && ref_edge
    |=> lo_r == 32'h0 && hi_r == $past(hi_r) + 32'h1)
    else $error("reference edge update wrong");
  AST_FREE_COUNT: assert property (@(posedge core_clk) disable iff (rst)
    ce && mode == TSC_M_FREE && src == TSC_SRC_FULL && !clr_req && samp_en
    |=> {hi_r, lo_r} == $past({hi_r, lo_r}) + 64'h1)
    else $error("free count did not advance");
  AST_WAIT_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    ce && busy_r ##1 ce |-> hi_r == 32'h0)
    else $error("counter not held at zero during clear");
  AST_TMO_FLAG: assert property (@(posedge core_clk) disable iff (rst)
    ce && busy_r && !ref_edge && ms_cnt_r >= tmo_r |=> tmo_err_r && !busy_r)
    else $error("timeout not reported");
  AST_AUX_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    ce && (cmd_r & TSC_AUX_ON) == 32'h0 |=> push.stamp[63:56] == 8'h00)
    else $error("upper byte not zero");
  AST_MULT: assert property (@(posedge core_clk) disable iff (rst)
    ce && bus.rd && bus.addr == TSC_IDX_MULT |=> rdata == MULTIPLIER)
    else $error("multiplier read wrong");
  // Stamp stream
  AST_GATE_OPEN: assert property (@(posedge core_clk) disable iff (rst)
    ce && gate && !gate_q_r && mode != TSC_M_OFF |=> push.valid)
    else $error("gate open did not push a stamp");
  AST_GATE_CLOSE: assert property (@(posedge core_clk) disable iff (rst)
    ce && !gate && gate_q_r && mode != TSC_M_OFF |=> push.valid)
    else $error("gate close did not push a stamp");
  AST_STAMP_LO: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> push.stamp[31:0] == $past(lo_r))
    else $error("stamp low word differs from counter");
  AST_AUX_BYTE: assert property (@(posedge core_clk) disable iff (rst)
    ce && (cmd_r & TSC_AUX_ON) != 32'h0 |=> push.stamp[63:56] == $past(aux_s))
    else $error("upper byte does not carry aux inputs");
  // Counter
  AST_SPLIT_LO: assert property (@(posedge core_clk) disable iff (rst)
    ce && !busy_r && !clr_req && mode == TSC_M_FREE && src != TSC_SRC_FULL && !ref_edge && samp_en
    |=> lo_r == $past(lo_r) + 32'h1 && hi_r == $past(hi_r))
    else $error("split low half did not advance");
  AST_RISE_ONLY: assert property (@(posedge core_clk) disable iff (rst)
    ce && !busy_r && !clr_req && mode == TSC_M_FREE && src == TSC_SRC_RISE && !ref_s && ref_q_r
    |=> hi_r == $past(hi_r))
    else $error("falling edge moved the high half in rise mode");
  AST_HOLD_NOSAMP: assert property (@(posedge core_clk) disable iff (rst)
    ce && !busy_r && !clr_req && !ref_edge && !samp_en && !acq_start
    |=> hi_r == $past(hi_r) && lo_r == $past(lo_r))
    else $error("counter moved without a sample");
  AST_OFF_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    ce && mode == TSC_M_OFF && !busy_r && !clr_req |=> hi_r == $past(hi_r) && lo_r == $past(lo_r))
    else $error("counter moved while off");
  // Clear sequence and supported modes bitmap
  AST_CLR_BUSY: assert property (@(posedge core_clk) disable iff (rst)
    ce && clr_req && src != TSC_SRC_FULL |=> busy_r && !tmo_err_r && !found_r)
    else $error("split clear did not start the edge wait");
  AST_FOUND: assert property (@(posedge core_clk) disable iff (rst)
    ce && busy_r && ref_edge && !clr_req |=> found_r && !busy_r)
    else $error("reference edge did not end the wait");
  AST_TIME_CAPT: assert property (@(posedge core_clk) disable iff (rst)
    ce && busy_r && ref_edge |=> time_r == ($past(pc_time) & 32'h00FF_FFFF))
    else $error("time of day not captured");
  AST_DATE_CAPT: assert property (@(posedge core_clk) disable iff (rst)
    ce && busy_r && ref_edge |=> date_r == $past(pc_date))
    else $error("calendar date not captured");
  AST_AVAIL: assert property (@(posedge core_clk) disable iff (rst)
    ce && bus.rd && bus.addr == TSC_IDX_AVAIL
    |=> (rdata & (TSC_CMD_FREE | TSC_CMD_ARM | TSC_CNT_FULL)) == (TSC_CMD_FREE | TSC_CMD_ARM | TSC_CNT_FULL))
    else $error("supported modes bitmap wrong");
endmodule

//--- tsc_ref_src.sv
// Purpose: reference pulse source model for the timestamp counter
// Assumes: the bench paces each half period of the pulse
// Notes: the line rests low between pulses
`timescale 1ns/1ps
module tsc_ref_src (
  output logic ref_out // Reference pulse line
);
  initial ref_out = 1'b0;
  // Hold one level for half of the 125 ns period
  task automatic drive(input logic v);
    ref_out = v;
    #62.5;
  endtask
endmodule

//--- tb_trigger_timestamp_counter.sv
// Purpose: self-checking bench for the trigger timestamp counter
// Assumes: samp_en toggles, so the count advances once per two core cycles
// Notes: split source cases are paced by the reference pulse model
`timescale 1ns/1ps
module tb_trigger_timestamp_counter import tsc_pkg::*;;
  typedef struct packed {
    logic [19:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } tsc_row_s;
  localparam logic [31:0] AVL = TSC_CMD_FREE | TSC_CMD_ARM | TSC_CNT_FULL | TSC_CNT_RISE | TSC_CNT_FALL;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic samp_en = 1'b0;
  logic acq_start = 1'b0;
  logic trig = 1'b0;
  logic gate = 1'b0;
  logic ref_clk_in;
  logic [7:0] aux_in = 8'hA5;
  logic [31:0] pc_time = 32'h0017_3B2A;
  logic [31:0] pc_date = 32'h07E8_0C1F;
  logic [31:0] rdata;
  logic [31:0] r;
  logic [63:0] s0, s1, s2;
  tsc_bus_s bus = '0;
  tsc_push_s push;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  tsc_row_s rows [8] = '{
    '{TSC_IDX_CMD, 1'b0, 32'h0, ALL, TSC_CMD_RST},
    '{TSC_IDX_TMO, 1'b0, 32'h0, ALL, TSC_TMO_RST},
    '{TSC_IDX_MULT, 1'b0, 32'h0, ALL, TSC_MULT_RST},
    '{TSC_IDX_RATE, 1'b0, 32'h0, ALL, TSC_RATE_RST},
    '{TSC_IDX_AVAIL, 1'b0, 32'h0, AVL, AVL},
    '{20'h00100, 1'b1, 32'h1234_5678, ALL, 32'h0},
    '{TSC_IDX_TIME, 1'b1, 32'h0001_0203, ALL, 32'h0001_0203},
    '{TSC_IDX_TMO, 1'b1, 32'h0000_0005, ALL, 32'h0000_0005}
  };

  // =====
  // Clock, sample enable, watchdog
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) samp_en <= ~samp_en;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  tsc_top #(.CYC_PER_MS(4)) DUT (.core_clk(core_clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
    .samp_en(samp_en), .acq_start(acq_start), .trig(trig), .gate(gate), .ref_clk_in(ref_clk_in),
    .aux_in(aux_in), .pc_time(pc_time), .pc_date(pc_date), .push(push));
  tsc_ref_src ref_src (.ref_out(ref_clk_in));

  // =====
  // Tasks
  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic chk_lt(input string nm, input logic [63:0] lim, input logic [63:0] g);
    n_compared++;
    if ((g < lim) !== 1'b1) begin
      num_errors++;
      $display("BAD %s exp below %0h got %0h", nm, lim, g);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, output logic [31:0] v);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Kind 0 trigger pulse, 1 gate opens, 2 gate closes
  task automatic ev(input int k, output logic [63:0] s);
    @(posedge core_clk);
    if (k == 0) trig <= 1'b1;
    else gate <= (k == 1);
    @(posedge core_clk);
    trig <= 1'b0;
    #1;
    chk("push_valid", 64'h1, {63'h0, push.valid});
    s = push.stamp;
  endtask
  task automatic pulse_acq();
    @(posedge core_clk);
    acq_start <= 1'b1;
    @(posedge core_clk);
    acq_start <= 1'b0;
  endtask

  // =====
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      chk($sformatf("reg %0h", rows[i].a), {32'h0, rows[i].e}, {32'h0, r & rows[i].m});
    end
    wr(TSC_IDX_CMD, TSC_CMD_FREE | TSC_CNT_FULL);
    repeat (60) @(posedge core_clk);
    wr(TSC_IDX_CMD, TSC_CMD_CLEAR);
    ev(0, s0);
    chk_lt("stamp_after_clear", 64'h10, s0);
    pulse_acq();
    repeat (8) @(posedge core_clk);
    ev(0, s1);
    chk("free_delta", s0 + 64'h6, s1);
    ev(1, s0);
    repeat (10) @(posedge core_clk);
    ev(2, s1);
    chk("gate_delta", s0 + 64'h6, s1);
    ev(0, s0);
    repeat (2) @(posedge core_clk);
    ce <= 1'b0;
    repeat (12) @(posedge core_clk);
    ce <= 1'b1;
    ev(0, s1);
    chk("ce_freeze", s0 + 64'h2, s1);
    wr(TSC_IDX_CMD, TSC_CMD_FREE | TSC_CNT_FULL | TSC_AUX_ON);
    ev(0, s0);
    chk("aux_byte", 64'hA5, {56'h0, s0[63:56]});
    wr(TSC_IDX_CMD, TSC_CMD_ARM | TSC_CNT_FULL);
    repeat (2) begin
      repeat (60) @(posedge core_clk);
      pulse_acq();
      ev(0, s0);
      chk_lt("arm_stamp", 64'h8, s0);
    end
    wr(TSC_IDX_CMD, TSC_CMD_OFF);
    @(posedge core_clk);
    trig <= 1'b1;
    repeat (3) begin
      @(posedge core_clk);
      trig <= 1'b0;
      #1;
      chk("off_valid", 64'h0, {63'h0, push.valid});
    end
    for (int k = 0; k < 2; k++) begin
      wr(TSC_IDX_CMD, TSC_CMD_FREE | (k == 0 ? TSC_CNT_RISE : TSC_CNT_FALL));
      wr(TSC_IDX_CMD, TSC_CMD_CLEAR);
      rd(TSC_IDX_STAT, r);
      chk("busy", 64'h1, {63'h0, r[TSC_ST_BUSY]});
      ref_src.drive(1'b1);
      ref_src.drive(1'b0);
      rd(TSC_IDX_STAT, r);
      chk("found", 64'h1, {63'h0, r[TSC_ST_FOUND]});
      rd(TSC_IDX_TIME, r);
      chk("sync_time", {32'h0, pc_time}, {32'h0, r});
      rd(TSC_IDX_DATE, r);
      chk("sync_date", {32'h0, pc_date}, {32'h0, r});
      ev(0, s0);
      chk_lt("split_hi_clear", 64'h2, {40'h0, s0[55:32]});
      ref_src.drive(1'b1);
      ev(0, s1);
      ref_src.drive(1'b0);
      ev(0, s2);
      chk("hi_after_rise", {40'h0, s0[55:32]} + (k == 0 ? 64'h1 : 64'h0), {40'h0, s1[55:32]});
      chk("hi_after_fall", {40'h0, s0[55:32]} + 64'h1, {40'h0, s2[55:32]});
      chk_lt("lo_restart", 64'h28, {32'h0, k == 0 ? s1[31:0] : s2[31:0]});
    end
    wr(TSC_IDX_CMD, TSC_CMD_FREE | TSC_CNT_RISE);
    wr(TSC_IDX_CMD, TSC_CMD_CLEAR);
    repeat (8) @(posedge core_clk);
    rd(TSC_IDX_STAT, r);
    chk("tmo_early", 64'h0, {63'h0, r[TSC_ST_TMO]});
    repeat (30) @(posedge core_clk);
    rd(TSC_IDX_STAT, r);
    chk("tmo_late", 64'h1, {63'h0, r[TSC_ST_TMO]});
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(TSC_IDX_CMD, r);
    chk("cmd_after_rst", {32'h0, TSC_CMD_RST}, {32'h0, r});
    rd(TSC_IDX_TMO, r);
    chk("tmo_after_rst", {32'h0, TSC_TMO_RST}, {32'h0, r});
    summarize();
  end
endmodule
